// >>> rtl/flash_sector_protect_pkg.sv
package flash_sector_protect_pkg;

  // ===========================================================
  // Register map (printed offsets are word indices)
  // ===========================================================
  localparam logic [7:0]  SWC_INDEX     = 8'h73;
  localparam logic [7:0]  FOS_INDEX     = 8'h74;
  localparam logic [7:0]  CTRL_INDEX    = 8'h75;
  localparam logic [9:0]  SWC_ADDR      = {SWC_INDEX, 2'b00};
  localparam logic [9:0]  FOS_ADDR      = {FOS_INDEX, 2'b00};
  localparam logic [9:0]  CTRL_ADDR     = {CTRL_INDEX, 2'b00};
  localparam int          ADDR_LSB_USED = 10;

  // ===========================================================
  // Field layout
  // ===========================================================
  localparam int          NUM_SECTORS   = 3;
  localparam int          SWC_RSV_LSB   = 3;
  localparam int          SWC_RSV_W     = 5;
  localparam int          FOS_FAULT_BIT = 0;
  localparam int          FOS_PGM_BIT   = 1;
  localparam int          FOS_ERS_BIT   = 2;
  localparam int          FOS_SUSP_BIT  = 3;
  localparam int          CTRL_SWAP_BIT = 0;
  localparam int          CTRL_GWE_BIT  = 1;

  // ===========================================================
  // Reset values
  // ===========================================================
  localparam logic [7:0]  SWC_RESET     = 8'h00;
  localparam logic [3:0]  FOS_RESET     = 4'h0;
  localparam logic [1:0]  CTRL_RESET    = 2'h0;

  // ===========================================================
  // Timing
  // ===========================================================
  localparam int          CLK_PERIOD_NS     = 100;
  localparam int          PGM_MAX_PERIOD_NS = 1000;
  localparam bit          PGM_FLAG_USABLE   = (CLK_PERIOD_NS <= PGM_MAX_PERIOD_NS);
  localparam int          STATUS_DELAY_CYC  = 2;

  // Command pipeline slots
  localparam int          CMD_SUSP      = 0;
  localparam int          CMD_ERS       = 1;
  localparam int          CMD_PGM       = 2;
  localparam int          CMD_RST       = 3;
  localparam int          CMD_W         = 4;

  // Register selects captured in the address phase
  typedef enum logic [3:0] {
    SEL_NONE = 4'b0001,
    SEL_SWC  = 4'b0010,
    SEL_FOS  = 4'b0100,
    SEL_CTRL = 4'b1000
  } reg_sel_t;

endpackage

// >>> rtl/flash_sector_protect_status.sv
// The AHB-Lite register port was chosen for this implementation.
`timescale 1ns/1ps
// Operation
// - Reset clears all sector enable bits
// - Writing one enables an unlocked sector
// - Writing zero locks sector permanently
// - Only reset releases a locked sector
// - Bits 2..0 upper/middle/lowest; 7..3 reserved
// - Global write enable zero blocks writes
// - Status register read-only, upper bits zero
// - Suspend flag set two cycles after command
// - Erase flag set two cycles after command
// - Program flag set two cycles after command
// - Program flag unusable above 1us clock
// - Fault flag clears two cycles after reset
// - Swap select exchanges vector area, middle sector
// - Chip erase only with all sectors enabled
module flash_sector_protect_status (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  input  wire logic        cmd_suspend,
  input  wire logic        cmd_resume,
  input  wire logic        cmd_sector_erase,
  input  wire logic        cmd_program,
  input  wire logic        cmd_reset,
  input  wire logic        cmd_chip_erase,
  input  wire logic        erase_done,
  input  wire logic        program_done,
  input  wire logic        cmd_fault,
  output logic [2:0]       sector_write_permit,
  output logic             sector_swap_active,
  output logic             chip_erase_accept
);

  // ===========================================================
  // State
  // ===========================================================
  typedef struct packed {
    logic [2:0]                 en;
    logic [2:0]                 lock;
    logic [4:0]                 rsv;
    logic                       gwe;
    logic                       swap;
    logic                       susp;
    logic                       ers;
    logic                       pgm;
    logic                       fault;
    logic [4:0]                 cmd_d1;
    logic                       wr_pend;
    flash_sector_protect_pkg::reg_sel_t sel;
    logic [31:0]                rdata;
    logic [2:0]                 permit;
    logic                       swap_out;
    logic                       chip_acc;
    logic                       ready;
  } state_t;

  state_t st_reg;
  state_t st_next;

  logic       access;
  logic [9:0] word_addr;
  flash_sector_protect_pkg::reg_sel_t sel_dec;

  assign access    = hsel & htrans[1] & hready;
  assign word_addr = haddr[9:0];

  always_comb begin
    unique case (word_addr)
      flash_sector_protect_pkg::SWC_ADDR:  sel_dec = flash_sector_protect_pkg::SEL_SWC;
      flash_sector_protect_pkg::FOS_ADDR:  sel_dec = flash_sector_protect_pkg::SEL_FOS;
      flash_sector_protect_pkg::CTRL_ADDR: sel_dec = flash_sector_protect_pkg::SEL_CTRL;
      default:                             sel_dec = flash_sector_protect_pkg::SEL_NONE;
    endcase
    if (haddr[31:flash_sector_protect_pkg::ADDR_LSB_USED] != '0) begin
      sel_dec = flash_sector_protect_pkg::SEL_NONE;
    end
  end

  // ===========================================================
  // Next state
  // ===========================================================
  always_comb begin
    st_next          = st_reg;
    st_next.ready    = 1'b1;
    st_next.wr_pend  = 1'b0;
    st_next.chip_acc = 1'b0;

    // Data phase write; zero wait states so hwdata is valid now
    if (st_reg.wr_pend) begin
      unique case (st_reg.sel)
        flash_sector_protect_pkg::SEL_SWC: begin
          st_next.rsv = hwdata[flash_sector_protect_pkg::SWC_RSV_LSB +:
                               flash_sector_protect_pkg::SWC_RSV_W];
          for (int i = 0; i < flash_sector_protect_pkg::NUM_SECTORS; i++) begin
            if (!hwdata[i]) begin
              st_next.en[i]   = 1'b0;
              st_next.lock[i] = 1'b1;
            end else if (!st_reg.lock[i]) begin
              st_next.en[i] = 1'b1;
            end
          end
        end
        flash_sector_protect_pkg::SEL_CTRL: begin
          st_next.gwe  = hwdata[flash_sector_protect_pkg::CTRL_GWE_BIT];
          st_next.swap = hwdata[flash_sector_protect_pkg::CTRL_SWAP_BIT];
        end
        // Status register ignores writes
        flash_sector_protect_pkg::SEL_FOS,
        flash_sector_protect_pkg::SEL_NONE: begin
        end
      endcase
    end

    // Address phase: capture select, prepare read data
    if (access) begin
      st_next.sel     = sel_dec;
      st_next.wr_pend = hwrite;
      st_next.rdata   = 32'h0000_0000;
      if (!hwrite) begin
        unique case (sel_dec)
          flash_sector_protect_pkg::SEL_SWC:
            st_next.rdata = {24'h00_0000, st_reg.rsv, st_reg.en};
          flash_sector_protect_pkg::SEL_FOS:
            st_next.rdata = {28'h000_0000, st_reg.susp, st_reg.ers,
                             st_reg.pgm, st_reg.fault};
          flash_sector_protect_pkg::SEL_CTRL:
            st_next.rdata = {30'h0000_0000, st_reg.gwe, st_reg.swap};
          flash_sector_protect_pkg::SEL_NONE:
            st_next.rdata = 32'h0000_0000;
        endcase
      end
    end

    // One pipeline stage gives the two-cycle status latency
    st_next.cmd_d1[flash_sector_protect_pkg::CMD_SUSP] = cmd_suspend;
    st_next.cmd_d1[flash_sector_protect_pkg::CMD_ERS]  = cmd_sector_erase;
    st_next.cmd_d1[flash_sector_protect_pkg::CMD_PGM]  = cmd_program;
    st_next.cmd_d1[flash_sector_protect_pkg::CMD_RST]  = cmd_reset;
    st_next.cmd_d1[4]                                  = 1'b0;

    if (cmd_resume) begin
      st_next.susp = 1'b0;
    end
    if (st_reg.cmd_d1[flash_sector_protect_pkg::CMD_SUSP]) begin
      st_next.susp = 1'b1;
    end
    if (erase_done) begin
      st_next.ers = 1'b0;
    end
    if (st_reg.cmd_d1[flash_sector_protect_pkg::CMD_ERS]) begin
      st_next.ers = 1'b1;
    end
    if (program_done) begin
      st_next.pgm = 1'b0;
    end
    if (st_reg.cmd_d1[flash_sector_protect_pkg::CMD_PGM] &&
        flash_sector_protect_pkg::PGM_FLAG_USABLE) begin
      st_next.pgm = 1'b1;
    end
    if (st_reg.cmd_d1[flash_sector_protect_pkg::CMD_RST]) begin
      st_next.fault = 1'b0;
    end
    // A fault in the clearing cycle still wins
    if (cmd_fault) begin
      st_next.fault = 1'b1;
    end

    // Blocked unless global enable is set
    st_next.permit   = {3{st_reg.gwe}} & st_reg.en & ~st_reg.lock;
    st_next.swap_out = st_reg.swap;
    st_next.chip_acc = cmd_chip_erase & st_reg.gwe & (&st_reg.en);
  end

  // ===========================================================
  // Registers
  // ===========================================================
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_reg          <= '0;
      st_reg.en       <= flash_sector_protect_pkg::SWC_RESET[2:0];
      st_reg.rsv      <= flash_sector_protect_pkg::SWC_RESET[7:3];
      st_reg.lock     <= 3'h0;
      st_reg.sel      <= flash_sector_protect_pkg::SEL_NONE;
      {st_reg.susp, st_reg.ers, st_reg.pgm, st_reg.fault} <=
        flash_sector_protect_pkg::FOS_RESET;
      {st_reg.gwe, st_reg.swap} <= flash_sector_protect_pkg::CTRL_RESET;
    end else begin
      st_reg <= st_next;
    end
  end

  assign hreadyout           = st_reg.ready;
  assign hresp               = 1'b0;
  assign hrdata              = st_reg.rdata;
  assign sector_write_permit = st_reg.permit;
  assign sector_swap_active  = st_reg.swap_out;
  assign chip_erase_accept   = st_reg.chip_acc;

  // ===========================================================
  // Checks
  // ===========================================================
  sequence swc_zero_write_s;
    st_reg.wr_pend && st_reg.sel == flash_sector_protect_pkg::SEL_SWC && !hwdata[1];
  endsequence

  sequence swc_one_write_s;
    st_reg.wr_pend && st_reg.sel == flash_sector_protect_pkg::SEL_SWC && hwdata[1];
  endsequence

  lock_sticky_a: assert property (@(posedge hclk) disable iff (!hresetn)
    swc_zero_write_s |=> st_reg.lock[1] && !st_reg.en[1])
    else $error("zero write did not lock sector");

  enable_unlocked_a: assert property (@(posedge hclk) disable iff (!hresetn)
    swc_one_write_s and !st_reg.lock[1] |=> st_reg.en[1])
    else $error("unlocked sector not enabled");

  lock_holds_a: assert property (@(posedge hclk) disable iff (!hresetn)
    st_reg.lock[1] |=> st_reg.lock[1] && !st_reg.en[1])
    else $error("lock released without reset");

  gwe_block_a: assert property (@(posedge hclk) disable iff (!hresetn)
    !st_reg.gwe |=> sector_write_permit == 3'h0)
    else $error("permit without global enable");

  permit_eq_a: assert property (@(posedge hclk) disable iff (!hresetn)
    1'b1 |=> sector_write_permit ==
             ($past(st_reg.en) & ~$past(st_reg.lock) & {3{$past(st_reg.gwe)}}))
    else $error("permit mismatch");

  fos_upper_a: assert property (@(posedge hclk) disable iff (!hresetn)
    st_reg.sel == flash_sector_protect_pkg::SEL_FOS |-> hrdata[31:4] == 28'h000_0000)
    else $error("status upper bits not zero");

  susp_delay_a: assert property (@(posedge hclk) disable iff (!hresetn)
    cmd_suspend ##1 !cmd_resume |=> st_reg.susp)
    else $error("suspend flag late");

  ers_delay_a: assert property (@(posedge hclk) disable iff (!hresetn)
    $rose(cmd_sector_erase) && !st_reg.ers |=> !st_reg.ers ##1 st_reg.ers)
    else $error("erase flag timing wrong");

  pgm_delay_a: assert property (@(posedge hclk) disable iff (!hresetn)
    cmd_program |-> ##2 st_reg.pgm)
    else $error("program flag late");

  fault_clear_a: assert property (@(posedge hclk) disable iff (!hresetn)
    cmd_reset ##1 !cmd_fault |=> !st_reg.fault)
    else $error("fault not cleared");

  chip_erase_a: assert property (@(posedge hclk) disable iff (!hresetn)
    chip_erase_accept |-> $past(st_reg.en) == 3'h7 && $past(cmd_chip_erase))
    else $error("chip erase with disabled sector");

endmodule

// >>> verification/flash_sector_protect_status_bench.sv
`timescale 1ns/1ps
module flash_sector_protect_status_bench;
  // ==========================================================
  // Signals and map
  // ==========================================================
  localparam logic [31:0] SWC  = {22'h0, flash_sector_protect_pkg::SWC_ADDR};
  localparam logic [31:0] FOS  = {22'h0, flash_sector_protect_pkg::FOS_ADDR};
  localparam logic [31:0] CTRL = {22'h0, flash_sector_protect_pkg::CTRL_ADDR};
  logic        hclk;
  logic        hresetn;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic        hreadyout;
  logic        hresp;
  logic [31:0] hrdata;
  logic [8:0]  cmd;
  logic [2:0]  permit;
  logic        swap;
  logic        accept;
  int          num_errors;
  int          total_checks;
  int          cycles;
  logic [3:0]  step_cmd [8] = '{4'h3, 4'h7, 4'h2, 4'h0, 4'h1, 4'h6, 4'h8, 4'h4};
  logic [3:0]  step_fos [8] = '{4'h2, 4'h0, 4'h4, 4'hc, 4'h4, 4'h0, 4'h1, 4'h0};

  flash_sector_protect_status DUT (
    .hclk                (hclk),
    .hresetn             (hresetn),
    .hsel                (hsel),
    .haddr               (haddr),
    .htrans              (htrans),
    .hwrite              (hwrite),
    .hsize               (hsize),
    .hwdata              (hwdata),
    .hready              (hreadyout),
    .hreadyout           (hreadyout),
    .hresp               (hresp),
    .hrdata              (hrdata),
    .cmd_suspend         (cmd[0]),
    .cmd_resume          (cmd[1]),
    .cmd_sector_erase    (cmd[2]),
    .cmd_program         (cmd[3]),
    .cmd_reset           (cmd[4]),
    .cmd_chip_erase      (cmd[5]),
    .erase_done          (cmd[6]),
    .program_done        (cmd[7]),
    .cmd_fault           (cmd[8]),
    .sector_write_permit (permit),
    .sector_swap_active  (swap),
    .chip_erase_accept   (accept)
  );

  initial begin
    hclk = 1'b0;
    forever #50 hclk = ~hclk;
  end

  // ==========================================================
  // Tasks
  // ==========================================================
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic results();
    if (num_errors == 0 && total_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // Master waits on hready; only the cycle ceiling ends a hang
  task automatic wait_ready();
    do @(posedge hclk); while (hreadyout !== 1'b1);
  endtask

  task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    htrans <= 2'b10;
    haddr  <= a;
    hwrite <= wr;
    wait_ready();
    htrans <= 2'b00;
    hwdata <= wd;
    wait_ready();
    rd = hrdata;
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] r;
    ahb(1'b1, a, d, r);
  endtask

  task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp);
    logic [31:0] r;
    ahb(1'b0, a, 32'h0, r);
    check(r, exp);
  endtask

  // Pulse one command line, then give the status three cycles to settle
  task automatic pulse(input logic [3:0] k);
    cmd <= 9'h001 << k;
    @(posedge hclk);
    cmd <= 9'h000;
    repeat (3) @(posedge hclk);
  endtask

  task automatic do_reset();
    hresetn <= 1'b0;
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
  endtask

  always @(posedge hclk) begin
    cycles++;
    if (cycles == 5000) begin
      num_errors++;
      results();
    end
  end

  // ==========================================================
  // Main sequence
  // ==========================================================
  initial begin
    hresetn = 1'b0;
    hsel    = 1'b1;
    haddr   = 32'h0;
    htrans  = 2'b00;
    hwrite  = 1'b0;
    hsize   = 3'b010;
    hwdata  = 32'h0;
    cmd     = 9'h000;
    do_reset();
    rd_chk(SWC, 32'h0);
    rd_chk(CTRL, 32'h0);
    rd_chk(32'h0000_0200, 32'h0);
    rd_chk(FOS, 32'h0);
    wr(SWC, 32'h0000_0007);
    rd_chk(SWC, 32'h0000_0007);
    check({29'h0, permit}, 32'h0);
    wr(CTRL, 32'h0000_0002);
    // Permit register trails the enable write by one more edge
    repeat (2) @(posedge hclk);
    check({29'h0, permit}, 32'h7);
    pulse(4'h5);
    wr(SWC, 32'hffff_ffff);
    rd_chk(SWC, 32'h0000_00ff);
    wr(SWC, 32'h0000_0005);
    rd_chk(SWC, 32'h0000_0005);
    check({29'h0, permit}, 32'h5);
    wr(SWC, 32'h0000_0007);
    rd_chk(SWC, 32'h0000_0005);
    check({29'h0, permit}, 32'h5);
    // Chip erase with a locked sector is ignored
    cmd <= 9'h020;
    @(posedge hclk);
    cmd <= 9'h000;
    @(posedge hclk);
    check({31'h0, accept}, 32'h0);
    wr(CTRL, 32'h0000_0003);
    repeat (2) @(posedge hclk);
    check({31'h0, swap}, 32'h1);
    wr(CTRL, 32'h0000_0000);
    repeat (2) @(posedge hclk);
    check({29'h0, permit}, 32'h0);
    do_reset();
    rd_chk(SWC, 32'h0);
    wr(CTRL, 32'h0000_0002);
    wr(SWC, 32'h0000_0007);
    rd_chk(SWC, 32'h0000_0007);
    cmd <= 9'h020;
    @(posedge hclk);
    cmd <= 9'h000;
    @(posedge hclk);
    check({31'h0, accept}, 32'h1);
    // Status walk: set, suspend, resume, complete, fault and clear
    for (int i = 0; i < 8; i++) begin
      pulse(step_cmd[i]);
      rd_chk(FOS, {28'h0, step_fos[i]});
    end
    pulse(4'h3);
    wr(FOS, 32'h0000_00f0);
    rd_chk(FOS, 32'h0000_0002);
    check({31'h0, hresp}, 32'h0);
    results();
  end
endmodule
